// >>> sim/fsc_status_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none

module fsc_status_regs_sva (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic eraseDone,
	input wire logic countCorrupt,
	input wire logic [15:0] resetExtCount_q,
	input wire logic eraseBusy_q
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence erase_run;
		eraseBusy_q ##[1:3] !eraseBusy_q;
	endsequence
	sequence corrupt_run;
		eraseBusy_q ##[1:2] !eraseBusy_q;
	endsequence
	ext_reset_value_a: assert property ($fell(rst) |-> resetExtCount_q == 16'hffff)
		else $error("reset extension count not at default");
	erase_update_a: assert property (eraseDone && !countCorrupt && !eraseBusy_q |=> erase_run)
		else $error("erase update timing wrong");
	corrupt_update_a: assert property (countCorrupt && !eraseBusy_q |=> corrupt_run)
		else $error("corrupt update timing wrong");
	busy_bound_a: assert property (eraseBusy_q [*2] |=> !eraseBusy_q)
		else $error("erase update too long");
	write_answer_a: assert property (wr_taken |=> ##[0:1] s_axi_bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
endmodule // fsc_status_regs_sva

`default_nettype wire

// >>> sim/test_fsc_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin badCount++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module test_fsc_status_regs;
	logic core_clk = 1'b0;
	logic rst;
	logic [7:0] s_axi_awaddr, s_axi_araddr, arrayByte, linkByte;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [5:0] opSector;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] resetExtCount_q;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, eraseDone, countCorrupt;
	logic arrayCrcStart, arrayByteValid, arrayCrcDone, linkCrcStart, linkByteValid, linkCrcDone;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, eraseBusy_q, irq_q;
	int badCount = 0;
	int totalChecks = 0;

	fsc_status_regs dut_u (.*);

	always #4 core_clk = ~core_clk;

	task automatic printVerdict;
		if (badCount == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		repeat (2) @(posedge core_clk);
		s_axi_bready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask

	task automatic rd(input [7:0] a, input [31:0] e, input [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge core_clk);
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, er)
	endtask

	// len above one holds the pulse into the busy window, where it must be ignored
	task automatic ev(input logic cor, input [5:0] s, input int len);
		@(posedge core_clk);
		eraseDone <= !cor;
		countCorrupt <= cor;
		opSector <= s;
		repeat (len) @(posedge core_clk);
		eraseDone <= 1'b0;
		countCorrupt <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask

	task automatic crc_run(input logic lnk, input [15:0] d);
		@(posedge core_clk);
		arrayCrcStart <= !lnk;
		linkCrcStart <= lnk;
		for (int i = 1; i >= 0; i--)
		begin
			@(posedge core_clk);
			arrayCrcStart <= 1'b0;
			linkCrcStart <= 1'b0;
			arrayByte <= d[i*8 +: 8];
			linkByte <= d[i*8 +: 8];
			arrayByteValid <= !lnk;
			linkByteValid <= lnk;
		end
		@(posedge core_clk);
		arrayByteValid <= 1'b0;
		linkByteValid <= 1'b0;
		arrayCrcDone <= !lnk;
		linkCrcDone <= lnk;
		@(posedge core_clk);
		arrayCrcDone <= 1'b0;
		linkCrcDone <= 1'b0;
	endtask

	function automatic [31:0] crc_of(input [15:0] d);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int i = 15; i >= 0; i--)
			c = (c << 1) ^ ((c[31] ^ d[i]) ? 32'h04c11db7 : 32'h00000000);
		return c;
	endfunction

	initial
	begin
		repeat (20000) @(posedge core_clk);
		badCount++;
		printVerdict();
	end

	initial
	begin
		logic [31:0] ro [3];
		ro = '{32'hff000000, 32'hffffffff, 32'h0fffffff};
		rst <= 1'b1;
		{s_axi_awaddr, s_axi_araddr, arrayByte, linkByte, s_axi_wdata, s_axi_wstrb, opSector} <= '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, eraseDone} <= '0;
		{countCorrupt, arrayCrcStart, arrayByteValid, arrayCrcDone, linkCrcStart, linkByteValid, linkCrcDone} <= '0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		rd(8'h00, 32'h0000ffff, 2'b00);
		for (int i = 0; i < 3; i++)
		begin
			wr(8'(4 * i + 4), 32'h00000000, 4'hf, 2'b00);
			rd(8'(4 * i + 4), ro[i], 2'b00);
		end
		wr(8'h00, 32'h00001234, 4'hf, 2'b00);
		wr(8'h00, 32'h0000abcd, 4'h1, 2'b00);
		rd(8'h00, 32'h000012cd, 2'b00);
		`CHK(resetExtCount_q, 16'h12cd)
		wr(8'h1c, 32'h00000001, 4'hf, 2'b10);
		rd(8'h1c, 32'h00000000, 2'b10);
		rd(8'h02, 32'h00000000, 2'b10);
		wr(8'h10, 32'h00000005, 4'hf, 2'b00);
		wr(8'h18, 32'h0000000f, 4'hf, 2'b00);
		ev(1'b0, 6'd5, 2);
		rd(8'h04, 32'hff000001, 2'b00);
		`CHK(irq_q, 1'b1)
		rd(8'h14, 32'h00000001, 2'b00);
		wr(8'h14, 32'h00000001, 4'hf, 2'b00);
		repeat (2) @(posedge core_clk);
		`CHK(irq_q, 1'b0)
		ev(1'b1, 6'd5, 1);
		rd(8'h04, 32'hff800000, 2'b00);
		ev(1'b0, 6'd5, 1);
		rd(8'h04, 32'hff000001, 2'b00);
		wr(8'h18, 32'h00000000, 4'hf, 2'b00);
		repeat (2) @(posedge core_clk);
		`CHK(irq_q, 1'b0)
		wr(8'h14, 32'h0000000f, 4'hf, 2'b00);
		crc_run(1'b0, 16'h3132);
		rd(8'h08, crc_of(16'h3132), 2'b00);
		crc_run(1'b1, 16'ha55a);
		rd(8'h0c, crc_of(16'ha55a), 2'b00);
		rd(8'h14, 32'h0000000c, 2'b00);
		printVerdict();
	end
endmodule // test_fsc_status_regs

bind fsc_status_regs fsc_status_regs_sva chk_u (.*);

`default_nettype wire

// >>> verilog/fsc_crc32.v
`timescale 1ns/1ps
`default_nettype none
`include "fsc_regs.vh"

// byte-serial crc engine, msb first
module fsc_crc32 #(
	parameter [31:0] POLY = 32'h04c11db7
) (
	input wire core_clk,
	input wire rst,
	input wire start,
	input wire [7:0] dataIn,
	input wire dataValid,
	output reg [31:0] crc_q
);

	reg [31:0] crc_d;
	reg [31:0] step;
	integer i;

	always @*
	begin
		step = crc_q;
		for (i = 7; i >= 0; i = i - 1)
		begin
			if (step[31] ^ dataIn[i])
			begin
				step = {step[30:0], 1'b0} ^ POLY;
			end
			else
			begin
				step = {step[30:0], 1'b0};
			end
		end
		if (start)
		begin
			crc_d = `FSC_RST_CRC_SEED;
		end
		else if (dataValid)
		begin
			crc_d = step;
		end
		else
		begin
			crc_d = crc_q;
		end
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			crc_q <= `FSC_RST_CRC_SEED;
		end
		else
		begin
			crc_q <= crc_d;
		end
	end

endmodule // fsc_crc32

`default_nettype wire

// >>> verilog/fsc_erase_mem.v
`timescale 1ns/1ps
`default_nettype none

// per-sector erase record, registered read data
module fsc_erase_mem #(
	parameter DW = 24,
	parameter AW = 6
) (
	input wire core_clk,
	input wire wrEn,
	input wire [AW-1:0] wrAddr,
	input wire [DW-1:0] wrData,
	input wire [AW-1:0] rdAddr,
	output reg [DW-1:0] rdData_q
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge core_clk)
	begin
		if (wrEn)
		begin
			mem[wrAddr] <= wrData;
		end
		rdData_q <= mem[rdAddr];
	end

endmodule // fsc_erase_mem

`default_nettype wire

// >>> verilog/fsc_regs.vh
`ifndef FSC_REGS_VH
`define FSC_REGS_VH

// register byte offsets
`define FSC_OFF_RESET_EXT 8'h00
`define FSC_OFF_ERASE_CNT 8'h04
`define FSC_OFF_ARRAY_CRC 8'h08
`define FSC_OFF_LINK_CRC 8'h0c
`define FSC_OFF_SECTOR_SEL 8'h10
`define FSC_OFF_IRQ_STATUS 8'h14
`define FSC_OFF_IRQ_MASK 8'h18

// reset values
`define FSC_RST_RESET_EXT 16'hffff
`define FSC_RST_ARRAY_CRC 32'hffffffff
`define FSC_RST_LINK_CRC 32'h0fffffff
`define FSC_RST_CRC_SEED 32'hffffffff
`define FSC_RST_RESERVED 8'hff

// erase count register fields
`define FSC_ECNT_VAL_MSB 22
`define FSC_ECNT_FLAG_BIT 23
`define FSC_ECNT_RSV_LSB 24
`define FSC_ECNT_MAX 23'h7fffff

// sector memory geometry
`define FSC_SECTOR_AW 6
`define FSC_SECTOR_NUM 64

// interrupt status bit positions
`define FSC_IRQ_ERASE 0
`define FSC_IRQ_CORRUPT 1
`define FSC_IRQ_ARRAY 2
`define FSC_IRQ_LINK 3
`define FSC_IRQ_W 4

// axi responses
`define FSC_RESP_OKAY 2'b00
`define FSC_RESP_SLVERR 2'b10

`endif

// >>> verilog/fsc_status_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "fsc_regs.vh"

module fsc_status_regs (
	input wire core_clk,
	input wire rst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire eraseDone,
	input wire countCorrupt,
	input wire [5:0] opSector,
	input wire arrayCrcStart,
	input wire [7:0] arrayByte,
	input wire arrayByteValid,
	input wire arrayCrcDone,
	input wire linkCrcStart,
	input wire [7:0] linkByte,
	input wire linkByteValid,
	input wire linkCrcDone,
	output reg [15:0] resetExtCount_q,
	output reg eraseBusy_q,
	output reg irq_q
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_READ = 3'b010;
	localparam [2:0] ST_WRITE = 3'b100;

	reg [7:0] awAddr_q;
	reg awFull_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	reg wFull_q;
	wire doWrite;

	reg [`FSC_SECTOR_AW-1:0] sectorSel_q;
	reg [`FSC_IRQ_W-1:0] irqStatus_q;
	reg [`FSC_IRQ_W-1:0] irqMask_q;
	reg [31:0] arrayChecksum_q;
	reg [31:0] linkCheck_q;

	reg [2:0] state_q;
	reg [`FSC_SECTOR_AW-1:0] curSector_q;
	reg [`FSC_SECTOR_NUM-1:0] entryValid_q;
	reg rdValid_q;
	// erase (1) or corruption (0) update in flight; kept apart from the read decode hit
	reg isErase_q;
	reg memWe;
	reg [23:0] memWdata;
	wire [`FSC_SECTOR_AW-1:0] memRdAddr;
	wire [23:0] memRdData;
	wire [22:0] eraseCountVal;
	wire eraseCountFlag;
	wire [31:0] eraseCountReg;

	wire [31:0] arrayCrc;
	wire [31:0] linkCrc;
	reg [`FSC_IRQ_W-1:0] irqEvents;
	reg [31:0] rdValue;
	reg rdHit;

	// write channel capture, either order
	assign doWrite = awFull_q & wFull_q & ~s_axi_bvalid;

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			awFull_q <= 1'b0;
			wFull_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FSC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awready & s_axi_awvalid)
			begin
				awAddr_q <= s_axi_awaddr;
				awFull_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			else if (doWrite)
			begin
				awFull_q <= 1'b0;
			end
			else if (~awFull_q & ~s_axi_bvalid)
			begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wready & s_axi_wvalid)
			begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
				wFull_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			else if (doWrite)
			begin
				wFull_q <= 1'b0;
			end
			else if (~wFull_q & ~s_axi_bvalid)
			begin
				s_axi_wready <= 1'b1;
			end
			if (doWrite)
			begin
				s_axi_bvalid <= 1'b1;
				if (awAddr_q <= `FSC_OFF_IRQ_MASK && awAddr_q[1:0] == 2'b00)
				begin
					s_axi_bresp <= `FSC_RESP_OKAY;
				end
				else
				begin
					s_axi_bresp <= `FSC_RESP_SLVERR;
				end
			end
			else if (s_axi_bvalid & s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// software-writable registers
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			resetExtCount_q <= `FSC_RST_RESET_EXT;
			sectorSel_q <= {`FSC_SECTOR_AW{1'b0}};
			irqMask_q <= {`FSC_IRQ_W{1'b0}};
		end
		else if (doWrite)
		begin
			if (awAddr_q == `FSC_OFF_RESET_EXT)
			begin
				if (wStrb_q[0])
				begin
					resetExtCount_q[7:0] <= wData_q[7:0];
				end
				if (wStrb_q[1])
				begin
					resetExtCount_q[15:8] <= wData_q[15:8];
				end
			end
			else if (awAddr_q == `FSC_OFF_SECTOR_SEL)
			begin
				if (wStrb_q[0])
				begin
					sectorSel_q <= wData_q[`FSC_SECTOR_AW-1:0];
				end
			end
			else if (awAddr_q == `FSC_OFF_IRQ_MASK)
			begin
				if (wStrb_q[0])
				begin
					irqMask_q <= wData_q[`FSC_IRQ_W-1:0];
				end
			end
			// erase count, checksum and link registers take no write path
		end
	end

	// erase record sequencer: corrupt writes directly, erase does read-modify-write
	assign memRdAddr = (state_q == ST_READ) ? curSector_q : sectorSel_q;

	always @*
	begin
		memWe = 1'b0;
		memWdata = 24'h000000;
		if (state_q == ST_WRITE)
		begin
			memWe = 1'b1;
			if (eraseBusy_q & ~isErase_q)
			begin
				// corruption: count reset to zero, flag raised
				memWdata = {1'b1, 23'h000000};
			end
			else if (rdValid_q & (memRdData[22:0] != `FSC_ECNT_MAX))
			begin
				memWdata = {1'b0, memRdData[22:0] + 23'h000001};
			end
			else if (rdValid_q)
			begin
				memWdata = {1'b0, memRdData[22:0]};
			end
			else
			begin
				memWdata = {1'b0, 23'h000001};
			end
		end
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			curSector_q <= {`FSC_SECTOR_AW{1'b0}};
			entryValid_q <= {`FSC_SECTOR_NUM{1'b0}};
			rdValid_q <= 1'b0;
			eraseBusy_q <= 1'b0;
			isErase_q <= 1'b0;
		end
		else
		begin
			rdValid_q <= entryValid_q[memRdAddr];
			case (state_q)
				ST_IDLE:
				begin
					if (countCorrupt)
					begin
						curSector_q <= opSector;
						isErase_q <= 1'b0;
						eraseBusy_q <= 1'b1;
						state_q <= ST_WRITE;
					end
					else if (eraseDone)
					begin
						curSector_q <= opSector;
						isErase_q <= 1'b1;
						eraseBusy_q <= 1'b1;
						state_q <= ST_READ;
					end
				end
				ST_READ:
				begin
					state_q <= ST_WRITE;
				end
				ST_WRITE:
				begin
					entryValid_q[curSector_q] <= 1'b1;
					eraseBusy_q <= 1'b0;
					state_q <= ST_IDLE;
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	fsc_erase_mem #(
		.DW(24),
		.AW(`FSC_SECTOR_AW)
	) u_erase_mem (
		.core_clk(core_clk),
		.wrEn(memWe),
		.wrAddr(curSector_q),
		.wrData(memWdata),
		.rdAddr(memRdAddr),
		.rdData_q(memRdData)
	);

	// unwritten sectors read as zero count, flag clear
	assign eraseCountVal = rdValid_q ? memRdData[`FSC_ECNT_VAL_MSB:0] : 23'h000000;
	assign eraseCountFlag = rdValid_q & memRdData[`FSC_ECNT_FLAG_BIT];
	assign eraseCountReg = {`FSC_RST_RESERVED, eraseCountFlag, eraseCountVal};

	// checksum engines
	fsc_crc32 u_array_crc (
		.core_clk(core_clk),
		.rst(rst),
		.start(arrayCrcStart),
		.dataIn(arrayByte),
		.dataValid(arrayByteValid),
		.crc_q(arrayCrc)
	);

	fsc_crc32 u_link_crc (
		.core_clk(core_clk),
		.rst(rst),
		.start(linkCrcStart),
		.dataIn(linkByte),
		.dataValid(linkByteValid),
		.crc_q(linkCrc)
	);

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			arrayChecksum_q <= `FSC_RST_ARRAY_CRC;
			linkCheck_q <= `FSC_RST_LINK_CRC;
		end
		else
		begin
			if (arrayCrcDone)
			begin
				arrayChecksum_q <= arrayCrc;
			end
			if (linkCrcDone)
			begin
				linkCheck_q <= linkCrc;
			end
		end
	end

	// sticky interrupt status, set wins over write-one-to-clear
	always @*
	begin
		irqEvents = {`FSC_IRQ_W{1'b0}};
		irqEvents[`FSC_IRQ_ERASE] = (state_q == ST_WRITE) & isErase_q;
		irqEvents[`FSC_IRQ_CORRUPT] = (state_q == ST_WRITE) & ~isErase_q;
		irqEvents[`FSC_IRQ_ARRAY] = arrayCrcDone;
		irqEvents[`FSC_IRQ_LINK] = linkCrcDone;
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			irqStatus_q <= {`FSC_IRQ_W{1'b0}};
			irq_q <= 1'b0;
		end
		else
		begin
			if (doWrite && awAddr_q == `FSC_OFF_IRQ_STATUS && wStrb_q[0])
			begin
				irqStatus_q <= (irqStatus_q & ~wData_q[`FSC_IRQ_W-1:0]) | irqEvents;
			end
			else
			begin
				irqStatus_q <= irqStatus_q | irqEvents;
			end
			irq_q <= |(irqStatus_q & irqMask_q);
		end
	end

	// read decode
	always @*
	begin
		rdValue = 32'h00000000;
		rdHit = 1'b1;
		if (s_axi_araddr == `FSC_OFF_RESET_EXT)
		begin
			rdValue = {16'h0000, resetExtCount_q};
		end
		else if (s_axi_araddr == `FSC_OFF_ERASE_CNT)
		begin
			rdValue = eraseCountReg;
		end
		else if (s_axi_araddr == `FSC_OFF_ARRAY_CRC)
		begin
			rdValue = arrayChecksum_q;
		end
		else if (s_axi_araddr == `FSC_OFF_LINK_CRC)
		begin
			rdValue = linkCheck_q;
		end
		else if (s_axi_araddr == `FSC_OFF_SECTOR_SEL)
		begin
			rdValue = {26'h0000000, sectorSel_q};
		end
		else if (s_axi_araddr == `FSC_OFF_IRQ_STATUS)
		begin
			rdValue = {28'h0000000, irqStatus_q};
		end
		else if (s_axi_araddr == `FSC_OFF_IRQ_MASK)
		begin
			rdValue = {28'h0000000, irqMask_q};
		end
		else
		begin
			rdHit = 1'b0;
		end
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `FSC_RESP_OKAY;
		end
		else if (s_axi_arready & s_axi_arvalid)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdValue;
			s_axi_rresp <= rdHit ? `FSC_RESP_OKAY : `FSC_RESP_SLVERR;
		end
		else if (s_axi_rvalid & s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
		else if (~s_axi_rvalid)
		begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule // fsc_status_regs

`default_nettype wire
